//--- testbench/ata_link_monitor.sv
// checker on the task-file link between host end and card end
`timescale 1ns/10ps
module ata_link_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic tf_wr,
  input wire logic [2:0] tf_addr,
  input wire logic [7:0] tf_wdata,
  input wire logic stat_rd,
  input wire logic dat_rd,
  input wire logic bsy,
  input wire logic drq,
  input wire logic intrq,
  input wire logic err,
  input wire logic abrt,
  input wire logic [7:0] tf_dh
);
  logic cmd_w;
  logic op_known;
  // a command write only counts while the card is free and selected
  assign cmd_w = tf_wr && tf_addr == ata_read_pkg::TF_CMD && !bsy && !drq
    && tf_dh[4] == ata_read_pkg::DRIVE_ID_DEF;
  assign op_known = tf_wdata == ata_read_pkg::OPC_READ_SECT
    || tf_wdata == ata_read_pkg::OPC_READ_SECT_OLD
    || tf_wdata == ata_read_pkg::OPC_READ_MULT
    || tf_wdata == ata_read_pkg::OPC_READ_MULT_EXT;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  busy_excl_a: assert property (!(bsy && drq))
    else $error("busy and data ready together");
  single_start_a: assert property (cmd_w && tf_dh[6] && (tf_wdata == 8'h20 || tf_wdata == 8'h21)
    |=> bsy && !abrt)
    else $error("single read not started");
  block_start_a: assert property (cmd_w && tf_wdata == 8'hC4
    |=> bsy || (err && abrt && intrq))
    else $error("block read neither started nor aborted");
  bad_op_a: assert property (cmd_w && !op_known |=> err && abrt && intrq && !bsy)
    else $error("unknown opcode not aborted");
  drq_irq_a: assert property ($rose(drq) |-> intrq && !bsy)
    else $error("data ready without interrupt");
  drq_hold_a: assert property ($fell(drq) |-> $past(dat_rd))
    else $error("data ready dropped without a word read");
  irq_cause_a: assert property ($rose(intrq) |-> drq || abrt)
    else $error("interrupt without block start or abort");
  irq_clear_a: assert property (stat_rd && drq && $past(drq) |-> ##[1:2] !intrq)
    else $error("status read did not clear interrupt");
endmodule : ata_link_monitor

//--- testbench/tb_ata_pio_read_commands.sv
// self-checking bench: host end and card end joined by the link
`timescale 1ns/10ps
module tb_ata_pio_read_commands;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic media_req;
  logic [47:0] media_lba;
  logic mvalid;
  logic mult_set = 1'b0;
  logic mult_en = 1'b0;
  logic [7:0] mult_cnt = 8'h00;
  logic [7:0] widx;
  logic [7:0] sec;
  logic [7:0] cerr_sec = 8'hFF;
  logic [7:0] uerr_sec = 8'hFF;
  int n_fail = 0;
  int num_checks = 0;
  always #25 core_clk_i = ~core_clk_i;
  ata_link_if link ();
  ata_read_host i_ata_read_host (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link(link),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
    .sw_rdata_o(sw_rdata));
  ata_read_device #(.MULT_MAX(2)) i_ata_read_device (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .link(link), .media_req_o(media_req), .media_lba_o(media_lba),
    .media_valid_i(mvalid), .media_data_i({sec, widx}),
    .media_cerr_i(mvalid && sec == cerr_sec), .media_uerr_i(mvalid && sec == uerr_sec),
    .mult_set_i(mult_set), .mult_count_i(mult_cnt), .mult_enable_i(mult_en));
  ata_link_monitor i_ata_link_monitor (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .tf_wr(link.tf_wr), .tf_addr(link.tf_addr), .tf_wdata(link.tf_wdata),
    .stat_rd(link.stat_rd), .dat_rd(link.dat_rd), .bsy(link.bsy), .drq(link.drq),
    .intrq(link.intrq), .err(link.err), .abrt(link.abrt), .tf_dh(link.tf_dh));
  // media: one word every other cycle; word carries sector tag and index
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mvalid <= 1'b0;
      widx <= 8'h00;
      sec <= 8'h00;
    end else begin
      mvalid <= media_req && !mvalid;
      if (mvalid) begin
        widx <= widx + 8'h01;
        if (widx == 8'hFF) sec <= sec + 8'h01;
      end
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk_i);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk_i);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : sw_read
  task automatic cmd28(input logic [7:0] op, input logic [7:0] cnt, input logic [23:0] lba);
    sw_write(4'h2, cnt);
    sw_write(4'h3, lba[7:0]);
    sw_write(4'h4, lba[15:8]);
    sw_write(4'h5, lba[23:16]);
    sw_write(4'h6, 8'hE0);
    sw_write(4'h7, op);
  endtask : cmd28
  // polls status; polling never raises an interrupt so nothing is lost
  task automatic wait_drq(output logic [15:0] st);
    int i;
    for (i = 0; i < 3000; i++) begin
      sw_read(4'h8, st);
      if (st[3] === 1'b1) break;
    end
    if (i == 3000) cmp(st, 16'h0008);
  endtask : wait_drq
  task automatic read_sec(input logic [7:0] s);
    logic [15:0] d;
    for (int i = 0; i < 256; i++) begin
      sw_read(4'h0, d);
      cmp(d, {s, i[7:0]});
    end
  endtask : read_sec
  task automatic t_abort;
    logic [7:0] ops [4] = '{8'hC4, 8'h29, 8'h00, 8'hC4};
    logic [15:0] st;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        @(posedge core_clk_i);
        mult_cnt <= 8'h02;
        mult_set <= 1'b1;
        @(posedge core_clk_i);
        mult_set <= 1'b0;
      end
      cmd28(ops[i], 8'h01, 24'h000000);
      sw_read(4'h8, st);
      cmp(st & 16'h00CD, 16'h0045);
    end
    $display("done abort");
  endtask : t_abort
  task automatic t_single;
    logic [7:0] ops [2] = '{8'h20, 8'h21};
    logic [15:0] st;
    logic [7:0] b;
    for (int i = 0; i < 2; i++) begin
      b = sec;
      cmd28(ops[i], 8'h02, 24'h000100);
      for (int k = 0; k < 2; k++) begin
        wait_drq(st);
        cmp(st & 16'h00C8, 16'h0048);
        read_sec(b + k[7:0]);
      end
      sw_read(4'h8, st);
      cmp(st & 16'h0088, 16'h0000);
      sw_read(4'h3, st);
      cmp(st & 16'h00FF, 16'h0001);
    end
    $display("done single");
  endtask : t_single
  task automatic t_block;
    logic [15:0] st;
    logic [7:0] b;
    @(posedge core_clk_i);
    mult_en <= 1'b1;
    b = sec;
    cerr_sec <= sec;
    cmd28(8'hC4, 8'h03, 24'h000200);
    wait_drq(st);
    cmp(st & 16'h00E8, 16'h0068);
    read_sec(b);
    sw_read(4'h8, st);
    cmp(st & 16'h0048, 16'h0008);
    read_sec(b + 8'h01);
    wait_drq(st);
    cmp(st & 16'h00C8, 16'h0048);
    read_sec(b + 8'h02);
    sw_read(4'h8, st);
    cmp(st & 16'h0088, 16'h0000);
    cerr_sec <= 8'hFF;
    $display("done block");
  endtask : t_block
  task automatic t_uerr;
    logic [15:0] st;
    logic [7:0] b;
    b = sec;
    uerr_sec <= sec;
    cmd28(8'hC4, 8'h04, 24'h000300);
    wait_drq(st);
    cmp(st & 16'h0059, 16'h0059);
    read_sec(b);
    read_sec(b + 8'h01);
    repeat (40) @(posedge core_clk_i);
    sw_read(4'h8, st);
    cmp(st & 16'h0088, 16'h0000);
    sw_read(4'h3, st);
    cmp(st & 16'h00FF, 16'h0000);
    uerr_sec <= 8'hFF;
    $display("done uncorrectable");
  endtask : t_uerr
  task automatic t_ext;
    logic [15:0] st;
    logic [7:0] b;
    b = sec;
    sw_write(4'h2, 8'h00);
    sw_write(4'h2, 8'h02);
    sw_write(4'h3, 8'h11);
    sw_write(4'h3, 8'hFE);
    sw_write(4'h4, 8'h22);
    sw_write(4'h4, 8'h00);
    sw_write(4'h5, 8'h33);
    sw_write(4'h5, 8'h00);
    sw_write(4'h6, 8'hE0);
    sw_read(4'h2, st);
    cmp(st, 16'h0002);
    sw_write(4'h7, 8'h29);
    wait_drq(st);
    cmp(st & 16'h00C8, 16'h0048);
    read_sec(b);
    read_sec(b + 8'h01);
    sw_read(4'h3, st);
    cmp(st, 16'h11FF);
    sw_read(4'h5, st);
    cmp(st, 16'h3300);
    cmp(media_lba[47:32], 16'h3322);
    cmp(media_lba[15:0], 16'h00FF);
    $display("done extended");
  endtask : t_ext
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  // about twelve sectors of traffic fit well inside this span
  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_abort();
    t_single();
    t_block();
    t_uerr();
    t_ext();
    stop_test();
  end
endmodule : tb_ata_pio_read_commands

//--- verilog/ata_link_if.sv
// task-file link between host controller and card
`timescale 1ns/10ps
interface ata_link_if;
  logic tf_wr;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata;
  logic stat_rd;
  logic dat_rd;
  logic bsy;
  logic drq;
  logic intrq;
  logic err;
  logic abrt;
  logic corr;
  logic unc;
  logic [15:0] dat_word;
  logic [15:0] dat_next;
  logic [7:0] tf_feat;
  logic [15:0] tf_count;
  logic [15:0] tf_low;
  logic [15:0] tf_mid;
  logic [15:0] tf_high;
  logic [7:0] tf_dh;
  modport dev (
    input tf_wr, tf_addr, tf_wdata, stat_rd, dat_rd,
    output bsy, drq, intrq, err, abrt, corr, unc, dat_word, dat_next,
    output tf_feat, tf_count, tf_low, tf_mid, tf_high, tf_dh
  );
  modport host (
    output tf_wr, tf_addr, tf_wdata, stat_rd, dat_rd,
    input bsy, drq, intrq, err, abrt, corr, unc, dat_word, dat_next,
    input tf_feat, tf_count, tf_low, tf_mid, tf_high, tf_dh
  );
endinterface : ata_link_if

//--- verilog/ata_read_device.sv
// card end: programmed-I/O read commands over the task-file link
// What this block does
// R1: opcode C4h starts 28-bit block read
// R2: opcode 29h starts 48-bit block read
// R3: 20h and 21h both start single read
// R4: block reads interrupt per block, not sector
// R5: DRQ checked only at block start
// R6: count register holds sectors, not blocks
// R7: last partial block is count mod block
// R8: block read without set-multiple is aborted
// R9: media error posted at block start, data sent
// R10: interrupt whenever DRQ rises per block
// R11: 28-bit count zero means 256 sectors
// R12: 48-bit count zero means 65536 sectors
// R13: error keeps failing address and buffer data
// R14: only correctable errors in block reads continue later blocks
// R15: completion leaves last sector address
// R16: single read: busy, load, DRQ, interrupt
// R17: host reads one block per data ready (one sector in single read)
// R18: block count of one always supported
// R19: 28-bit address split over bytes and nibble
// R20: 48-bit registers hold previous and current byte
`timescale 1ns/10ps
module ata_read_device #(
  parameter int MULT_MAX = ata_read_pkg::MULT_MAX_DEF,
  parameter logic DRIVE_ID = ata_read_pkg::DRIVE_ID_DEF
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  ata_link_if.dev link,
  output logic media_req_o,
  output logic [47:0] media_lba_o,
  input wire logic media_valid_i,
  input wire logic [15:0] media_data_i,
  input wire logic media_cerr_i,
  input wire logic media_uerr_i,
  input wire logic mult_set_i,
  input wire logic [7:0] mult_count_i,
  input wire logic mult_enable_i
);
  localparam int SEC_W = $clog2(MULT_MAX + 1);
  localparam int IDX_W = $clog2(MULT_MAX) + ata_read_pkg::WORD_IDX_W;
  localparam int CNT_W = SEC_W + ata_read_pkg::WORD_IDX_W;

  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_XFER} state_type;

  state_type state;
  logic ext;
  logic single;
  logic mult_valid;
  logic [SEC_W-1:0] mult_blk;
  logic [SEC_W-1:0] blk_size;
  logic [SEC_W-1:0] sec_cnt;
  logic [7:0] word_cnt;
  logic [16:0] remain;
  logic [CNT_W-1:0] rd_cnt;
  logic [CNT_W-1:0] blk_words;
  logic [IDX_W-1:0] rd_idx;
  logic sec_cerr;
  logic sec_uerr;
  logic blk_cerr;
  logic blk_uerr;
  logic err_seen;

  function automatic logic [47:0] lba_of(input logic e, input logic [15:0] lo,
      input logic [15:0] mi, input logic [15:0] hi, input logic [3:0] nib);
    if (e) begin
      lba_of = {hi[15:8], mi[15:8], lo[15:8], hi[7:0], mi[7:0], lo[7:0]}; // R20
    end else begin
      lba_of = {20'h00000, nib, hi[7:0], mi[7:0], lo[7:0]}; // R19
    end
  endfunction : lba_of

  // command decode
  logic cmd_wr;
  logic is_single;
  logic is_m28;
  logic is_m48;
  logic is_multi;
  logic reject;
  logic [16:0] start_cnt;
  assign cmd_wr = link.tf_wr && link.tf_addr == ata_read_pkg::TF_CMD && state == ST_IDLE
    && link.tf_dh[ata_read_pkg::DH_DRV_BIT] == DRIVE_ID; // R19
  assign is_single = link.tf_wdata == ata_read_pkg::OPC_READ_SECT
    || link.tf_wdata == ata_read_pkg::OPC_READ_SECT_OLD; // R3
  assign is_m28 = link.tf_wdata == ata_read_pkg::OPC_READ_MULT; // R1
  assign is_m48 = link.tf_wdata == ata_read_pkg::OPC_READ_MULT_EXT; // R2
  assign is_multi = is_m28 || is_m48;
  assign reject = !(is_single || is_multi)
    || (is_multi && !(mult_valid && mult_enable_i)) // R8
    || (!is_m48 && !link.tf_dh[ata_read_pkg::DH_LBA_BIT]);
  always_comb begin
    if (is_m48) begin
      start_cnt = link.tf_count == '0 ? ata_read_pkg::COUNT48_MAX
        : {1'b0, link.tf_count}; // R12 R6
    end else begin
      start_cnt = link.tf_count[7:0] == '0 ? ata_read_pkg::COUNT28_MAX
        : {9'h000, link.tf_count[7:0]}; // R11 R6
    end
  end

  // fill and transfer events
  logic sector_done;
  logic block_full;
  logic cerr_now;
  logic uerr_now;
  logic xfer_done;
  logic stop;
  logic advance;
  logic [47:0] next_lba;
  assign cerr_now = sec_cerr || media_cerr_i;
  assign uerr_now = sec_uerr || media_uerr_i;
  assign sector_done = state == ST_FILL && media_valid_i
    && word_cnt == ata_read_pkg::WORD_LAST;
  assign block_full = sector_done
    && (sec_cnt + 1'b1 == blk_size || remain == ata_read_pkg::COUNT_ONE); // R7
  assign xfer_done = state == ST_XFER && link.dat_rd
    && rd_cnt == blk_words - 1'b1; // R5
  // uncorrectable stops after the block; in single mode any error ends the read
  assign stop = remain == '0 || blk_uerr || (single && blk_cerr); // R14 R13
  assign advance = ((sector_done && !block_full && !cerr_now && !uerr_now)
    || (xfer_done && !stop)) && !err_seen; // R13 R15
  assign next_lba = media_lba_o + 48'h000000000001;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mult_valid <= 1'b0;
      mult_blk <= '0;
    end else if (mult_set_i) begin
      mult_valid <= mult_count_i != '0 && 32'(mult_count_i) <= MULT_MAX; // R18
      mult_blk <= mult_count_i[SEC_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      ext <= 1'b0;
      single <= 1'b0;
      blk_size <= '0;
      remain <= '0;
      media_lba_o <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_wr && !reject) begin
            state <= ST_FILL;
            ext <= is_m48;
            single <= is_single;
            blk_size <= is_multi ? mult_blk : SEC_W'(1); // R4 R16
            remain <= start_cnt;
            media_lba_o <= lba_of(is_m48, link.tf_low, link.tf_mid, link.tf_high,
              link.tf_dh[3:0]);
          end
        end
        ST_FILL: begin
          if (sector_done) begin
            remain <= remain - ata_read_pkg::COUNT_ONE;
          end
          if (block_full) begin
            state <= ST_XFER;
          end
          if (advance) begin
            media_lba_o <= next_lba;
          end
        end
        ST_XFER: begin
          if (xfer_done) begin
            state <= stop ? ST_IDLE : ST_FILL;
          end
          if (advance) begin
            media_lba_o <= next_lba;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_cnt <= '0;
      word_cnt <= '0;
      sec_cerr <= 1'b0;
      sec_uerr <= 1'b0;
      blk_cerr <= 1'b0;
      blk_uerr <= 1'b0;
      err_seen <= 1'b0;
      blk_words <= '0;
      rd_cnt <= '0;
    end else if (cmd_wr) begin
      sec_cnt <= '0;
      word_cnt <= '0;
      sec_cerr <= 1'b0;
      sec_uerr <= 1'b0;
      blk_cerr <= 1'b0;
      blk_uerr <= 1'b0;
      err_seen <= 1'b0;
    end else if (state == ST_FILL && media_valid_i) begin
      word_cnt <= word_cnt + 8'h01;
      sec_cerr <= sector_done ? 1'b0 : cerr_now;
      sec_uerr <= sector_done ? 1'b0 : uerr_now;
      if (sector_done) begin
        sec_cnt <= block_full ? '0 : sec_cnt + 1'b1;
        blk_cerr <= blk_cerr || cerr_now;
        blk_uerr <= blk_uerr || uerr_now;
        err_seen <= err_seen || cerr_now || uerr_now; // R13
      end
      if (block_full) begin
        blk_words <= {sec_cnt + 1'b1, 8'h00};
        rd_cnt <= '0;
      end
    end else if (state == ST_XFER && link.dat_rd) begin
      rd_cnt <= rd_cnt + 1'b1;
      if (xfer_done) begin
        blk_cerr <= 1'b0; // errors are posted per block
        blk_uerr <= 1'b0;
      end
    end
  end

  // link status; the hardware set wins over a status read clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.bsy <= 1'b0;
      link.drq <= 1'b0;
      link.intrq <= 1'b0;
      link.err <= 1'b0;
      link.abrt <= 1'b0;
      link.corr <= 1'b0;
      link.unc <= 1'b0;
    end else begin
      if (cmd_wr) begin
        link.bsy <= !reject; // R16
        link.err <= reject;
        link.abrt <= reject; // R8
        link.corr <= 1'b0;
        link.unc <= 1'b0;
      end else if (block_full) begin
        link.bsy <= 1'b0;
        link.drq <= 1'b1; // R16 R5
        link.err <= link.err || blk_cerr || cerr_now || blk_uerr || uerr_now; // R9
        link.corr <= link.corr || blk_cerr || cerr_now;
        link.unc <= link.unc || blk_uerr || uerr_now;
      end else if (xfer_done) begin
        link.drq <= 1'b0;
        link.bsy <= !stop;
      end
      if (block_full || (cmd_wr && reject)) begin
        link.intrq <= 1'b1; // R10 R4
      end else if (link.stat_rd || cmd_wr) begin
        link.intrq <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      media_req_o <= 1'b0;
    end else begin
      media_req_o <= (cmd_wr && !reject) || (xfer_done && !stop)
        || (media_req_o && !block_full);
    end
  end

  // task file: host count and address writes shift previous byte; device writes back the address
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.tf_feat <= '0;
      link.tf_count <= '0;
      link.tf_low <= '0;
      link.tf_mid <= '0;
      link.tf_high <= '0;
      link.tf_dh <= '0;
    end else if (state == ST_IDLE && !link.drq) begin
      if (link.tf_wr) begin
        unique case (link.tf_addr)
          ata_read_pkg::TF_FEAT: link.tf_feat <= link.tf_wdata;
          ata_read_pkg::TF_COUNT: link.tf_count <= {link.tf_count[7:0], link.tf_wdata}; // R20
          ata_read_pkg::TF_LOW: link.tf_low <= {link.tf_low[7:0], link.tf_wdata};
          ata_read_pkg::TF_MID: link.tf_mid <= {link.tf_mid[7:0], link.tf_wdata};
          ata_read_pkg::TF_HIGH: link.tf_high <= {link.tf_high[7:0], link.tf_wdata};
          ata_read_pkg::TF_DH: link.tf_dh <= link.tf_wdata;
          default: ;
        endcase
      end
    end else if (ext) begin
      link.tf_low <= {media_lba_o[31:24], media_lba_o[7:0]}; // R15 R13
      link.tf_mid <= {media_lba_o[39:32], media_lba_o[15:8]};
      link.tf_high <= {media_lba_o[47:40], media_lba_o[23:16]};
    end else begin
      link.tf_low[7:0] <= media_lba_o[7:0]; // R13
      link.tf_mid[7:0] <= media_lba_o[15:8];
      link.tf_high[7:0] <= media_lba_o[23:16];
      link.tf_dh[3:0] <= media_lba_o[27:24];
    end
  end

  // buffer read ports look one and two words ahead of the host
  logic [IDX_W-1:0] idx_a;
  logic [IDX_W-1:0] idx_b;
  logic [15:0] word_a;
  logic [15:0] word_b;
  assign idx_a = state == ST_XFER ? rd_idx + 1'b1 : '0;
  assign idx_b = state == ST_XFER ? rd_idx + 2'h2 : IDX_W'(1);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_idx <= '0;
      link.dat_word <= '0;
      link.dat_next <= '0;
    end else if (block_full || (state == ST_XFER && link.dat_rd)) begin
      rd_idx <= block_full ? '0 : rd_idx + 1'b1;
      link.dat_word <= word_a;
      link.dat_next <= word_b;
    end
  end

  sector_buffer #(
    .WIDTH(16),
    .IDX_W(IDX_W)
  ) i_sector_buffer (
    .core_clk_i(core_clk_i),
    .wr_en_i(state == ST_FILL && media_valid_i),
    .wr_idx_i(IDX_W'({sec_cnt, word_cnt})),
    .wr_data_i(media_data_i),
    .rd_idx_a_i(idx_a),
    .rd_data_a_o(word_a),
    .rd_idx_b_i(idx_b),
    .rd_data_b_o(word_b)
  );
endmodule : ata_read_device

//--- verilog/ata_read_host.sv
// host controller end: software port onto the task-file link
`timescale 1ns/10ps
module ata_read_host (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  ata_link_if.host link,
  input wire logic [3:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o
);
  logic tf_sel;
  logic [7:0] status;
  assign tf_sel = !sw_addr_i[3] && sw_addr_i[2:0] != '0;
  always_comb begin
    status = '0;
    status[ata_read_pkg::ST_BSY] = link.bsy;
    status[ata_read_pkg::ST_INTRQ] = link.intrq;
    status[ata_read_pkg::ST_CORR] = link.corr;
    status[ata_read_pkg::ST_UNC] = link.unc;
    status[ata_read_pkg::ST_DRQ] = link.drq;
    status[ata_read_pkg::ST_ABRT] = link.abrt;
    status[ata_read_pkg::ST_ERR] = link.err;
  end

  // task-file writes pass to the card one cycle later
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.tf_wr <= 1'b0;
      link.tf_addr <= '0;
      link.tf_wdata <= '0;
    end else begin
      link.tf_wr <= sw_wr_i && tf_sel; // R1 R2 R3 R6 R19 R20
      if (sw_wr_i) begin
        link.tf_addr <= sw_addr_i[2:0];
        link.tf_wdata <= sw_wdata_i;
      end
    end
  end

  // a data word is popped only while the card offers data
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.dat_rd <= 1'b0;
      link.stat_rd <= 1'b0;
    end else begin
      link.dat_rd <= sw_rd_i && sw_addr_i == ata_read_pkg::HOST_DATA
        && link.drq && !link.bsy; // R17 R5
      // clear only an interrupt the read reported; one raised meanwhile must survive
      link.stat_rd <= sw_rd_i && sw_addr_i == ata_read_pkg::HOST_STATUS && link.intrq;
    end
  end

  // a pop still in flight means the card's current word is already taken
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_rdata_o <= '0;
    end else if (sw_rd_i) begin
      unique case (sw_addr_i)
        ata_read_pkg::HOST_DATA: sw_rdata_o <= link.dat_rd ? link.dat_next : link.dat_word;
        ata_read_pkg::HOST_STATUS: sw_rdata_o <= {8'h00, status};
        {1'b0, ata_read_pkg::TF_FEAT}: sw_rdata_o <= {8'h00, link.tf_feat};
        {1'b0, ata_read_pkg::TF_COUNT}: sw_rdata_o <= link.tf_count;
        {1'b0, ata_read_pkg::TF_LOW}: sw_rdata_o <= link.tf_low;
        {1'b0, ata_read_pkg::TF_MID}: sw_rdata_o <= link.tf_mid;
        {1'b0, ata_read_pkg::TF_HIGH}: sw_rdata_o <= link.tf_high;
        {1'b0, ata_read_pkg::TF_DH}: sw_rdata_o <= {8'h00, link.tf_dh};
        default: sw_rdata_o <= '0;
      endcase
    end
  end
endmodule : ata_read_host

//--- verilog/ata_read_pkg.sv
// shared constants for the task-file read command path
package ata_read_pkg;
  localparam logic [7:0] OPC_READ_SECT = 8'h20;
  localparam logic [7:0] OPC_READ_SECT_OLD = 8'h21;
  localparam logic [7:0] OPC_READ_MULT = 8'hC4;
  localparam logic [7:0] OPC_READ_MULT_EXT = 8'h29;
  localparam logic [2:0] TF_FEAT = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_LOW = 3'h3;
  localparam logic [2:0] TF_MID = 3'h4;
  localparam logic [2:0] TF_HIGH = 3'h5;
  localparam logic [2:0] TF_DH = 3'h6;
  localparam logic [2:0] TF_CMD = 3'h7;
  localparam logic [3:0] HOST_DATA = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h8;
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRV_BIT = 4;
  localparam int WORD_IDX_W = 8;
  localparam logic [7:0] WORD_LAST = 8'hFF;
  localparam logic [16:0] COUNT28_MAX = 17'h00100;
  localparam logic [16:0] COUNT48_MAX = 17'h10000;
  localparam logic [16:0] COUNT_ONE = 17'h00001;
  localparam int MULT_MAX_DEF = 1;
  localparam logic DRIVE_ID_DEF = 1'b0;
  localparam int ST_BSY = 7;
  localparam int ST_INTRQ = 6;
  localparam int ST_CORR = 5;
  localparam int ST_UNC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ABRT = 2;
  localparam int ST_ERR = 0;
endpackage : ata_read_pkg

//--- verilog/sector_buffer.sv
// flip-flop sector buffer, one write port and two read ports
`timescale 1ns/10ps
module sector_buffer #(
  parameter int WIDTH = 16,
  parameter int IDX_W = 8
) (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [IDX_W-1:0] wr_idx_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [IDX_W-1:0] rd_idx_a_i,
  output logic [WIDTH-1:0] rd_data_a_o,
  input wire logic [IDX_W-1:0] rd_idx_b_i,
  output logic [WIDTH-1:0] rd_data_b_o
);
  logic [WIDTH-1:0] mem [2**IDX_W];

  // data only, so no reset: keeps the array cheap
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  assign rd_data_a_o = mem[rd_idx_a_i];
  assign rd_data_b_o = mem[rd_idx_b_i];
endmodule : sector_buffer
